// ===== verilog/pfc_pkg.sv
// Package: constants, register map and carriers for the flow action comparator
package pfc_pkg;
  localparam int NUM_FLOWS   = 4;
  localparam int HDR_BYTES   = 32;
  localparam int ACT_W       = 4;
  localparam int CLK_NS      = 25;
  // Shared words: mask, status, hit count
  localparam logic [11:0] MASK_LO_OFS    = 12'h000;
  localparam logic [11:0] MASK_HI_OFS    = 12'h004;
  localparam logic [11:0] STATUS_OFS     = 12'h008;
  localparam logic [11:0] HIT_COUNT_OFS  = 12'h00C;
  // Per-flow block: base + flow * stride
  localparam logic [11:0] FLOW_BASE      = 12'h100;
  localparam logic [11:0] FLOW_STRIDE    = 12'h020;
  localparam logic [4:0]  MATCH_LO_OFS   = 5'h00;
  localparam logic [4:0]  MATCH_HI_OFS   = 5'h04;
  localparam logic [4:0]  RANGE_OFS      = 5'h08;
  localparam logic [4:0]  ACTION_OFS     = 5'h0C;
  localparam logic [4:0]  ZERO_OFS       = 5'h10;
  // Field positions
  localparam int RNG_LO_POS   = 0;
  localparam int RNG_HI_POS   = 8;
  localparam int RNG_EN_POS   = 16;
  localparam int RNG_PTR_POS  = 24;
  localparam int ACT_CODE_POS = 0;
  localparam int ACT_SAVE_POS = 4;
  localparam int ACT_ADD_POS  = 5;
  localparam int ACT_SUB_POS  = 6;
  localparam int ACT_CF_POS   = 8;
  localparam int ACT_TS_POS   = 16;
  localparam int ZERO_ST_POS  = 0;
  localparam int ZERO_CNT_POS = 8;
  // Reset values
  localparam logic [63:0] MASK_RST  = 64'h0000000000000000;
  localparam logic [31:0] WORD_RST  = 32'h00000000;
  // OAM frames compare only the first four header bytes
  localparam logic [63:0] OAM_KEEP  = 64'hFFFFFFFF00000000;
  localparam logic [1:0]  RESP_OKAY   = 2'h0;
  localparam logic [1:0]  RESP_SLVERR = 2'h2;

  typedef enum logic [ACT_W-1:0] {
    PFC_ACT_KEEP       = 4'h0,
    PFC_ACT_SUB_TIME   = 4'h1,
    PFC_ACT_LAT_PATH   = 4'h2,
    PFC_ACT_ADD_TIME   = 4'h3,
    PFC_ACT_RESIDENCE  = 4'h4,
    PFC_ACT_STORE_TIME = 4'h5,
    PFC_ACT_STORE_PATH = 4'h6,
    PFC_ACT_STORE_NS   = 4'h7,
    PFC_ACT_STORE_NSPD = 4'h8
  } pfc_action_e;

  typedef struct packed {
    logic       cf_sub_time;
    logic       cf_add_time;
    logic       cf_sub_latency;
    logic       cf_add_latency;
    logic       cf_add_path;
    logic       cf_sub_storage;
    logic       cf_write_path;
    logic       ts_write_time;
    logic       ns_write_time;
    logic       ns_add_peer;
    logic       cf_action_store_nanoseconds;
  } pfc_ops_s;

  typedef struct packed {
    logic        hit;
    logic [1:0]  flow;
    logic [3:0]  code;
    pfc_ops_s    ops;
    logic        save_time;
    logic        asym_add;
    logic        asym_sub;
    logic [4:0]  cf_ptr;
    logic [5:0]  ts_ptr;
    logic [5:0]  zero_start;
    logic [3:0]  zero_count;
    logic        zero_en;
  } pfc_result_s;
endpackage

// ===== verilog/pfc_flow_comparator.sv
// Flow action comparator: per-flow header match, range check and action select
`timescale 1ns/10ps
`default_nettype none
module pfc_flow_comparator
  import pfc_pkg::*;
(
  input  wire logic                             aclk,
  input  wire logic                             aresetn,
  input  wire logic [11:0]                      s_axi_awaddr,
  input  wire logic                             s_axi_awvalid,
  output logic                                  s_axi_awready,
  input  wire logic [31:0]                      s_axi_wdata,
  input  wire logic [3:0]                       s_axi_wstrb,
  input  wire logic                             s_axi_wvalid,
  output logic                                  s_axi_wready,
  output logic [1:0]                            s_axi_bresp,
  output logic                                  s_axi_bvalid,
  input  wire logic                             s_axi_bready,
  input  wire logic [11:0]                      s_axi_araddr,
  input  wire logic                             s_axi_arvalid,
  output logic                                  s_axi_arready,
  output logic [31:0]                           s_axi_rdata,
  output logic [1:0]                            s_axi_rresp,
  output logic                                  s_axi_rvalid,
  input  wire logic                             s_axi_rready,
  input  wire logic                             hdr_valid,
  input  wire logic                             hdr_is_oam,
  input  wire logic [pfc_pkg::HDR_BYTES-1:0][7:0] hdr_bytes,
  input  wire logic [pfc_pkg::NUM_FLOWS-1:0]    prior_match,
  output logic                                  result_valid,
  output pfc_pkg::pfc_result_s                  result
);
  import pfc_pkg::*;

  ////////////////////////////////////////////////////////////////////////////
  // Register storage
  logic [63:0]                 mask_r;
  logic [NUM_FLOWS-1:0][63:0]  match_r;
  logic [NUM_FLOWS-1:0][31:0]  range_r;
  logic [NUM_FLOWS-1:0][31:0]  action_r;
  logic [NUM_FLOWS-1:0][31:0]  zero_r;
  logic [31:0]                 hit_count_r;

  logic        aw_held_r;
  logic        w_held_r;
  logic [11:0] awaddr_r;
  logic [31:0] wdata_r;
  logic [3:0]  wstrb_r;

  // Decode: bit 8 = mapped, [7:5] = kind, [1:0] = flow
  function automatic logic [8:0] reg_decode(input logic [11:0] a);
    logic [11:0] rel;
    logic [2:0]  kind;
    rel  = a - FLOW_BASE;
    kind = 3'h0;
    reg_decode = 9'h000;
    if (a[1:0] != 2'h0) begin
      reg_decode = 9'h000;
    end else if (a == MASK_LO_OFS) begin
      reg_decode = 9'h100;
    end else if (a == MASK_HI_OFS) begin
      reg_decode = 9'h120;
    end else if (a == STATUS_OFS) begin
      reg_decode = 9'h140;
    end else if (a == HIT_COUNT_OFS) begin
      reg_decode = 9'h160;
    end else if (a >= FLOW_BASE && rel < 12'(NUM_FLOWS) * FLOW_STRIDE
                 && rel[4:0] <= ZERO_OFS) begin
      // Zero word shares kind seven with the action word; a sum would wrap to zero
      kind = (rel[4:0] == ZERO_OFS) ? 3'h7 : 3'h4 + rel[4:2];
      reg_decode = {1'b1, kind, 3'h0, rel[6:5]};
    end
  endfunction

  function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d,
                                        input logic [3:0] strb);
    for (int i = 0; i < 4; i++) begin
      merge[i*8 +: 8] = strb[i] ? d[i*8 +: 8] : old[i*8 +: 8];
    end
  endfunction

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite write channel
  logic       wr_fire;
  logic [8:0] wr_dec;
  logic [1:0] wr_flow;
  assign s_axi_awready = !aw_held_r && !s_axi_bvalid;
  assign s_axi_wready  = !w_held_r && !s_axi_bvalid;
  assign wr_fire       = aw_held_r && w_held_r && !s_axi_bvalid;
  assign wr_dec        = reg_decode(awaddr_r);
  assign wr_flow       = wr_dec[1:0];

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      aw_held_r <= 1'b0;
      w_held_r  <= 1'b0;
      awaddr_r  <= 12'h000;
      wdata_r   <= WORD_RST;
      wstrb_r   <= 4'h0;
    end else begin
      if (s_axi_awvalid && s_axi_awready) begin
        aw_held_r <= 1'b1;
        awaddr_r  <= s_axi_awaddr;
      end else if (wr_fire) begin
        aw_held_r <= 1'b0;
      end
      if (s_axi_wvalid && s_axi_wready) begin
        w_held_r <= 1'b1;
        wdata_r  <= s_axi_wdata;
        wstrb_r  <= s_axi_wstrb;
      end else if (wr_fire) begin
        w_held_r <= 1'b0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_bvalid <= 1'b0;
      s_axi_bresp  <= RESP_OKAY;
    end else if (wr_fire) begin
      s_axi_bvalid <= 1'b1;
      s_axi_bresp  <= wr_dec[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_bready) begin
      s_axi_bvalid <= 1'b0;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      mask_r <= MASK_RST;
    end else if (wr_fire && wr_dec == 9'h100) begin
      mask_r[31:0] <= merge(mask_r[31:0], wdata_r, wstrb_r);
    end else if (wr_fire && wr_dec == 9'h120) begin
      mask_r[63:32] <= merge(mask_r[63:32], wdata_r, wstrb_r);
    end
  end

  // per-flow settings, one copy per flow
  generate
    for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_flow_regs
      logic sel;
      assign sel = wr_fire && wr_dec[8] && wr_dec[7] && wr_flow == 2'(f);
      always_ff @(posedge aclk) begin
        if (!aresetn) begin
          match_r[f]  <= 64'h0000000000000000;
          range_r[f]  <= WORD_RST;
          action_r[f] <= WORD_RST;
          zero_r[f]   <= WORD_RST;
        end else if (sel) begin
          case (wr_dec[7:5])
            3'h4: match_r[f][31:0]  <= merge(match_r[f][31:0], wdata_r, wstrb_r);
            3'h5: match_r[f][63:32] <= merge(match_r[f][63:32], wdata_r, wstrb_r);
            3'h6: range_r[f]        <= merge(range_r[f], wdata_r, wstrb_r);
            3'h7: begin
              if (awaddr_r[4:0] == ZERO_OFS) begin
                zero_r[f] <= merge(zero_r[f], wdata_r, wstrb_r);
              end else begin
                action_r[f] <= merge(action_r[f], wdata_r, wstrb_r);
              end
            end
            default: ;
          endcase
        end
      end
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // AXI4-Lite read channel, answer one cycle after address taken
  logic [8:0]  rd_dec;
  logic [31:0] rd_word;
  assign s_axi_arready = !s_axi_rvalid;
  assign rd_dec        = reg_decode(s_axi_araddr);

  always_comb begin
    rd_word = WORD_RST;
    case (rd_dec[7:5])
      3'h0: rd_word = mask_r[31:0];
      3'h1: rd_word = mask_r[63:32];
      3'h2: rd_word = {24'h000000, result_valid, result.hit, 4'h0, result.flow};
      3'h3: rd_word = hit_count_r;
      3'h4: rd_word = match_r[rd_dec[1:0]][31:0];
      3'h5: rd_word = match_r[rd_dec[1:0]][63:32];
      3'h6: rd_word = range_r[rd_dec[1:0]];
      3'h7: rd_word = (s_axi_araddr[4:0] == ZERO_OFS) ? zero_r[rd_dec[1:0]]
                                                       : action_r[rd_dec[1:0]];
      default: rd_word = WORD_RST;
    endcase
    if (!rd_dec[8]) rd_word = WORD_RST;
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      s_axi_rvalid <= 1'b0;
      s_axi_rdata  <= WORD_RST;
      s_axi_rresp  <= RESP_OKAY;
    end else if (s_axi_arvalid && s_axi_arready) begin
      s_axi_rvalid <= 1'b1;
      s_axi_rdata  <= rd_word;
      s_axi_rresp  <= rd_dec[8] ? RESP_OKAY : RESP_SLVERR;
    end else if (s_axi_rready) begin
      s_axi_rvalid <= 1'b0;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Header compare
  logic [63:0]          hdr64;
  logic [63:0]          eff_mask;
  logic [NUM_FLOWS-1:0] flow_hit;

  // byte 0 of the header lands in the top bits of the match word
  always_comb begin
    for (int b = 0; b < 8; b++) begin
      hdr64[63 - b*8 -: 8] = hdr_bytes[b];
    end
  end

  // OAM drops bytes four to seven from the compare
  assign eff_mask = hdr_is_oam ? (mask_r & OAM_KEEP) : mask_r;

  generate
    for (genvar f = 0; f < NUM_FLOWS; f++) begin : g_cmp
      logic [7:0] sel_byte;
      logic       in_range;
      logic       field_ok;
      assign sel_byte = hdr_bytes[range_r[f][RNG_PTR_POS +: 5]];
      assign in_range = sel_byte >= range_r[f][RNG_LO_POS +: 8]
                     && sel_byte <= range_r[f][RNG_HI_POS +: 8];
      assign field_ok = ((hdr64 ^ match_r[f]) & eff_mask) == 64'h0000000000000000;
      // bounds ignored while the check is off
      assign flow_hit[f] = prior_match[f] && field_ok
                        && (!range_r[f][RNG_EN_POS] || in_range);
    end
  endgenerate

  ////////////////////////////////////////////////////////////////////////////
  // Action decode
  // code 0 nothing, code 1 subtract captured time
  // code 2 minus latency plus path delay
  // code 4 time plus latency minus stored field
  // code 5 store captured time only
  // code 6 store time, path delay to correction
  // code 7 nanoseconds into new field
  // code 8 nanoseconds plus peer delay, also to correction
  function automatic pfc_ops_s action_ops(input logic [ACT_W-1:0] code);
    action_ops = '0;
    case (pfc_action_e'(code))
      PFC_ACT_SUB_TIME:   action_ops.cf_sub_time = 1'b1;
      PFC_ACT_LAT_PATH: begin
        action_ops.cf_sub_latency = 1'b1;
        action_ops.cf_add_path    = 1'b1;
      end
      PFC_ACT_ADD_TIME:   action_ops.cf_add_time = 1'b1;
      PFC_ACT_RESIDENCE: begin
        action_ops.cf_add_time    = 1'b1;
        action_ops.cf_add_latency = 1'b1;
        action_ops.cf_sub_storage = 1'b1;
      end
      PFC_ACT_STORE_TIME: action_ops.ts_write_time = 1'b1;
      PFC_ACT_STORE_PATH: begin
        action_ops.ts_write_time = 1'b1;
        action_ops.cf_write_path = 1'b1;
      end
      PFC_ACT_STORE_NS:   action_ops.ns_write_time = 1'b1;
      PFC_ACT_STORE_NSPD: begin
        action_ops.ns_write_time = 1'b1;
        action_ops.ns_add_peer   = 1'b1;
        action_ops.cf_action_store_nanoseconds   = 1'b1;
      end
      default: action_ops = '0;
    endcase
  endfunction

  // Lowest numbered flow wins when several match
  pfc_result_s res_nxt;
  always_comb begin
    res_nxt = '0;
    for (int f = NUM_FLOWS - 1; f >= 0; f--) begin
      if (flow_hit[f]) begin
        res_nxt.hit        = 1'b1;
        res_nxt.flow       = 2'(f);
        res_nxt.code       = action_r[f][ACT_CODE_POS +: ACT_W];
        res_nxt.ops        = action_ops(action_r[f][ACT_CODE_POS +: ACT_W]);
        res_nxt.save_time  = action_r[f][ACT_SAVE_POS];
        res_nxt.asym_add   = action_r[f][ACT_ADD_POS];
        res_nxt.asym_sub   = action_r[f][ACT_SUB_POS];
        res_nxt.cf_ptr     = action_r[f][ACT_CF_POS +: 5];
        res_nxt.ts_ptr     = action_r[f][ACT_TS_POS +: 6];
        res_nxt.zero_start = zero_r[f][ZERO_ST_POS +: 6];
        res_nxt.zero_count = zero_r[f][ZERO_CNT_POS +: 4];
        res_nxt.zero_en    = zero_r[f][ZERO_CNT_POS +: 4] != 4'h0;
      end
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      result_valid <= 1'b0;
      result       <= '0;
    end else begin
      result_valid <= hdr_valid;
      if (hdr_valid) result <= res_nxt;
    end
  end

  always_ff @(posedge aclk) begin
    if (!aresetn) begin
      hit_count_r <= WORD_RST;
    end else if (hdr_valid && res_nxt.hit) begin
      hit_count_r <= hit_count_r + 32'h00000001;
    end
  end

  ////////////////////////////////////////////////////////////////////////////
  // Checks
  default clocking cb @(posedge aclk); endclocking
  default disable iff (!aresetn);

  oam_mask_a: assert property (hdr_valid && hdr_is_oam |-> (eff_mask & ~OAM_KEEP) == 64'h0)
    else $error("OAM compare uses bytes beyond four");
  ptp_mask_a: assert property (hdr_valid && !hdr_is_oam |-> eff_mask == mask_r)
    else $error("PTP compare mask altered");
  hit_needs_match_a: assert property (hdr_valid && res_nxt.hit |->
      ((hdr64 ^ match_r[res_nxt.flow]) & eff_mask) == 64'h0)
    else $error("Hit on mismatching header");
  range_gate_a: assert property (hdr_valid && res_nxt.hit && range_r[res_nxt.flow][RNG_EN_POS]
      |-> hdr_bytes[range_r[res_nxt.flow][RNG_PTR_POS +: 5]]
          >= range_r[res_nxt.flow][RNG_LO_POS +: 8])
    else $error("Range lower bound ignored");
  result_timing_a: assert property (hdr_valid |=> result_valid && result.hit == $past(res_nxt.hit))
    else $error("Result not one cycle after header");
  zero_off_a: assert property (result_valid && result.zero_count == 4'h0 |-> !result.zero_en)
    else $error("Zeroing on with zero count");
  nop_quiet_a: assert property (result_valid && result.code == 4'h0 |-> result.ops == '0)
    else $error("Code zero drives an operation");
  peer_code_a: assert property (result_valid && result.code == 4'h8 |->
      result.ops.ns_write_time && result.ops.cf_action_store_nanoseconds && result.ops.ns_add_peer)
    else $error("Code eight decode wrong");
  save_flag_a: assert property (hdr_valid && res_nxt.hit |=>
      result.save_time == $past(action_r[res_nxt.flow][ACT_SAVE_POS]))
    else $error("Save control not carried");
  bresp_a: assert property (wr_fire |=> s_axi_bvalid)
    else $error("Write response missing");

  hit_c:   cover property (hdr_valid && res_nxt.hit);
  oam_c:   cover property (hdr_valid && hdr_is_oam && res_nxt.hit);
  range_c: cover property (hdr_valid && !res_nxt.hit && range_r[0][RNG_EN_POS]);
  write_c: cover property (wr_fire ##1 s_axi_bvalid && s_axi_bready);
endmodule
`default_nettype wire

// ===== verification/pfc_hdr_source.sv
// Header source and result sink standing in for the neighbouring analyzer stages
`timescale 1ns/10ps
`default_nettype none
module pfc_hdr_source
  import pfc_pkg::*;
(
  input  wire logic                              aclk,
  input  wire logic                              result_valid,
  input  wire pfc_pkg::pfc_result_s              result,
  output logic                                   hdr_valid,
  output logic                                   hdr_is_oam,
  output logic [pfc_pkg::HDR_BYTES-1:0][7:0]     hdr_bytes,
  output logic [pfc_pkg::NUM_FLOWS-1:0]          prior_match
);
  int          n;
  logic        got_v;
  pfc_result_s got;

  initial begin
    hdr_valid = 1'b0;
    hdr_is_oam = 1'b0;
    hdr_bytes = '0;
    prior_match = '0;
    n = 0;
    got = '0;
    got_v = 1'b0;
  end

  // One header per call; bytes past the first eight, other than byte 20, change on every call
  task automatic send(input logic oam, input logic [63:0] w, input logic [7:0] rb,
                      input logic [3:0] pm);
    logic [HDR_BYTES-1:0][7:0] b;
    for (int i = 0; i < HDR_BYTES; i++) b[i] = 8'h5A ^ 8'(i + n);
    for (int i = 0; i < 8; i++) b[i] = w[63-8*i -: 8];
    b[20] = rb;
    @(posedge aclk);
    hdr_valid <= 1'b1;
    hdr_is_oam <= oam;
    hdr_bytes <= b;
    prior_match <= pm;
    @(posedge aclk);
    hdr_valid <= 1'b0;
    // Stale data must not look valid between frames
    hdr_is_oam <= ~oam;
    hdr_bytes <= ~b;
    prior_match <= ~pm;
    // Result and its valid still stand at this edge, before any update lands
    @(posedge aclk);
    got = result;
    got_v = result_valid;
    n++;
  endtask
endmodule
`default_nettype wire

// ===== verification/ptp_oam_flow_action_comparator_tb.sv
// Testbench: register access, header match, range check and action decode
`timescale 1ns/10ps
`default_nettype none
module ptp_oam_flow_action_comparator_tb;
  import pfc_pkg::*;
  logic                      aclk, aresetn;
  logic [11:0]               awaddr, araddr;
  logic [31:0]               wdata, rdata;
  logic [3:0]                wstrb;
  logic [1:0]                bresp, rresp;
  logic                      awvalid, awready, wvalid, wready, bvalid, bready;
  logic                      arvalid, arready, rvalid, rready;
  logic                      hdr_valid, hdr_is_oam, result_valid;
  logic [HDR_BYTES-1:0][7:0] hdr_bytes;
  logic [NUM_FLOWS-1:0]      prior_match;
  pfc_result_s               result;
  int                        err_count, n_compared, cyc, n_hit;
  logic [31:0]               act_cfg [NUM_FLOWS];
  logic [31:0]               zero_cfg [NUM_FLOWS];
  localparam logic [63:0] HW = 64'h1122334455667788;
  localparam logic [10:0] OPS_TBL [16] = '{1:11'h400, 2:11'h140, 3:11'h200, 4:11'h2A0,
    5:11'h008, 6:11'h018, 7:11'h004, 8:11'h007, default:11'h000};

  initial aclk = 1'b0;
  always #12.5 aclk = ~aclk;

  pfc_flow_comparator u_pfc_flow_comparator (
    .aclk(aclk), .aresetn(aresetn), .s_axi_awaddr(awaddr), .s_axi_awvalid(awvalid),
    .s_axi_awready(awready), .s_axi_wdata(wdata), .s_axi_wstrb(wstrb),
    .s_axi_wvalid(wvalid), .s_axi_wready(wready), .s_axi_bresp(bresp),
    .s_axi_bvalid(bvalid), .s_axi_bready(bready), .s_axi_araddr(araddr),
    .s_axi_arvalid(arvalid), .s_axi_arready(arready), .s_axi_rdata(rdata),
    .s_axi_rresp(rresp), .s_axi_rvalid(rvalid), .s_axi_rready(rready),
    .hdr_valid(hdr_valid), .hdr_is_oam(hdr_is_oam), .hdr_bytes(hdr_bytes),
    .prior_match(prior_match), .result_valid(result_valid), .result(result));

  pfc_hdr_source u_pfc_hdr_source (
    .aclk(aclk), .result_valid(result_valid), .result(result), .hdr_valid(hdr_valid),
    .hdr_is_oam(hdr_is_oam), .hdr_bytes(hdr_bytes), .prior_match(prior_match));

  task automatic stop_test;
    $display("compares %0d mismatches %0d", n_compared, err_count);
    if (err_count == 0 && n_compared > 0) $display("Testbench passed");
    else $display("Testbench failed");
    $finish;
  endtask

  task automatic fail(input string m);
    err_count++;
    $display("MISMATCH t=%0t %s", $time, m);
  endtask

  function automatic logic [11:0] fa(input int f, input logic [4:0] ofs);
    return FLOW_BASE + FLOW_STRIDE * 12'(f) + 12'(ofs);
  endfunction

  task automatic wr(input logic [11:0] a, input logic [31:0] d, input logic [3:0] s,
                    input logic [1:0] er);
    logic aw, w;
    aw = 1'b0;
    w = 1'b0;
    awaddr <= a;
    wdata <= d;
    wstrb <= s;
    awvalid <= 1'b1;
    wvalid <= 1'b1;
    while (!(aw && w)) begin
      @(posedge aclk);
      if (awready && !aw) begin
        aw = 1'b1;
        awvalid <= 1'b0;
      end
      if (wready && !w) begin
        w = 1'b1;
        wvalid <= 1'b0;
      end
    end
    bready <= 1'b1;
    do @(posedge aclk); while (!bvalid);
    bready <= 1'b0;
    n_compared++;
    if (bresp !== er) fail("write response");
  endtask

  task automatic rd(input logic [11:0] a, input logic [31:0] ed, input logic [1:0] er);
    araddr <= a;
    arvalid <= 1'b1;
    do @(posedge aclk); while (!arready);
    arvalid <= 1'b0;
    rready <= 1'b1;
    do @(posedge aclk); while (!rvalid);
    rready <= 1'b0;
    n_compared++;
    if (rdata !== ed || rresp !== er) fail("read data or response");
  endtask

  task automatic set_act(input int f, input logic [31:0] v);
    act_cfg[f] = v;
    wr(fa(f, ACTION_OFS), v, 4'hF, RESP_OKAY);
  endtask

  task automatic set_zero(input int f, input logic [31:0] v);
    zero_cfg[f] = v;
    wr(fa(f, ZERO_OFS), v, 4'hF, RESP_OKAY);
  endtask

  // Expected result built from the settings the bench wrote
  task automatic chk(input logic oam, input logic [63:0] w, input logic [7:0] rb,
                     input logic [3:0] pm, input logic hit, input int f);
    pfc_result_s e;
    logic [31:0] a, z;
    a = act_cfg[f];
    z = zero_cfg[f];
    e = '0;
    if (hit) begin
      n_hit++;
      e = '{hit: 1'b1, flow: 2'(f), code: a[3:0], ops: pfc_ops_s'(OPS_TBL[a[3:0]]),
            save_time: a[4], asym_add: a[5], asym_sub: a[6], cf_ptr: a[12:8],
            ts_ptr: a[21:16], zero_start: z[5:0], zero_count: z[11:8], zero_en: |z[11:8]};
    end
    u_pfc_hdr_source.send(oam, w, rb, pm);
    n_compared++;
    if (u_pfc_hdr_source.got_v !== 1'b1 || u_pfc_hdr_source.got !== e) fail("flow result");
  endtask

  always @(posedge aclk) begin
    cyc++;
    if (cyc == 20000) begin
      fail("timeout");
      stop_test();
    end
  end

  initial begin
    {aresetn, awvalid, wvalid, bready, arvalid, rready} = '0;
    {awaddr, araddr, wdata, wstrb} = '0;
    act_cfg = '{default: '0};
    zero_cfg = '{default: '0};
    {err_count, n_compared, cyc, n_hit} = '0;
    repeat (20) @(posedge aclk);
    aresetn <= 1'b1;
    rd(MASK_LO_OFS, WORD_RST, RESP_OKAY);
    rd(fa(3, ACTION_OFS), WORD_RST, RESP_OKAY);
    wr(MASK_LO_OFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    wr(MASK_LO_OFS, 32'h00000000, 4'h2, RESP_OKAY);
    rd(MASK_LO_OFS, 32'hFFFF00FF, RESP_OKAY);
    wr(MASK_HI_OFS, 32'hFFFFFFFF, 4'hF, RESP_OKAY);
    wr(12'h800, 32'h00000001, 4'hF, RESP_SLVERR);
    rd(12'h800, 32'h00000000, RESP_SLVERR);
    rd(12'h002, 32'h00000000, RESP_SLVERR);
    wr(fa(1, MATCH_LO_OFS), HW[31:0], 4'hF, RESP_OKAY);
    wr(fa(1, MATCH_HI_OFS), HW[63:32], 4'hF, RESP_OKAY);
    $display("test registers done");
    chk(1'b0, HW, 8'h05, 4'h2, 1'b1, 1);
    chk(1'b0, HW ^ 64'hFF00, 8'h05, 4'h2, 1'b1, 1);
    chk(1'b0, HW ^ 64'h1, 8'h05, 4'h2, 1'b0, 1);
    chk(1'b0, HW ^ {1'b1, 63'h0}, 8'h05, 4'h2, 1'b0, 1);
    chk(1'b1, HW ^ 64'h12345678, 8'h05, 4'h2, 1'b1, 1);
    chk(1'b0, HW ^ 64'h12345678, 8'h05, 4'h2, 1'b0, 1);
    chk(1'b0, HW, 8'h05, 4'h0, 1'b0, 1);
    $display("test match done");
    wr(fa(1, RANGE_OFS), 32'h14011410, 4'hF, RESP_OKAY);
    rd(fa(1, RANGE_OFS), 32'h14011410, RESP_OKAY);
    chk(1'b0, HW, 8'h10, 4'h2, 1'b1, 1);
    chk(1'b0, HW, 8'h14, 4'h2, 1'b1, 1);
    chk(1'b0, HW, 8'h0F, 4'h2, 1'b0, 1);
    chk(1'b0, HW, 8'h15, 4'h2, 1'b0, 1);
    wr(fa(1, RANGE_OFS), 32'h14001410, 4'hF, RESP_OKAY);
    chk(1'b0, HW, 8'h05, 4'h2, 1'b1, 1);
    $display("test range done");
    // Codes 0 to 9; code 9 must decode to no operation
    for (int c = 0; c < 10; c++) begin
      set_act(1, 32'(c));
      chk(1'b0, HW, 8'h05, 4'h2, 1'b1, 1);
    end
    set_act(1, 32'h003F1F78);
    rd(fa(1, ACTION_OFS), 32'h003F1F78, RESP_OKAY);
    set_zero(1, 32'h00000F3F);
    chk(1'b0, HW, 8'h05, 4'h2, 1'b1, 1);
    set_zero(1, 32'h0000003F);
    chk(1'b0, HW, 8'h05, 4'h2, 1'b1, 1);
    $display("test actions done");
    wr(fa(0, MATCH_LO_OFS), HW[31:0], 4'hF, RESP_OKAY);
    wr(fa(0, MATCH_HI_OFS), HW[63:32], 4'hF, RESP_OKAY);
    set_act(0, 32'h00000003);
    wr(fa(1, RANGE_OFS), 32'h14011410, 4'hF, RESP_OKAY);
    chk(1'b0, HW, 8'h05, 4'h3, 1'b1, 0);
    chk(1'b0, HW, 8'h05, 4'h2, 1'b0, 1);
    chk(1'b0, HW, 8'h12, 4'h2, 1'b1, 1);
    rd(HIT_COUNT_OFS, 32'(n_hit), RESP_OKAY);
    rd(STATUS_OFS, 32'h00000041, RESP_OKAY);
    $display("test flows done");
    stop_test();
  end
endmodule
`default_nettype wire
